//--- rtl/nsov_trip.sv
// Negative sequence definite-time overvoltage start and trip logic with AXI4-Lite registers.
//
// Contract
// RQ1: Start is high exactly while measured magnitude is above the start level.
// RQ2: Trip only after full delay elapses in start, and not in start-only mode.
// RQ3: Start and trip are suppressed when disabled by setting or block input.
// RQ4: Operating time equals configured delay regardless of how far level is exceeded.
// RQ5: Start and timing depend only on the negative sequence magnitude.
// RQ6: Outputs formed in a decision stage from states, config flags and block input.
// RQ7: Upstream supplies the negative sequence RMS magnitude as the measured input.
// RQ8: Start level is integer percent, 2 to 40, step one, default 30.
// RQ9: Trip delay in ms, 50 to 60000, step one, default 100.
// RQ10: Start-only flag, default false, keeps start while never asserting trip.
// RQ11: Block input comes from user logic outside; asserting it disables function.
// RQ12: Timer clears and start drops at or below level, or when blocked.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "nsov_defines.svh"
module nsov_trip #(
  parameter int unsigned CYC_PER_MS = `NSOV_CYC_PER_MS
) (
  // Clock and reset.
  input  wire logic        I_CLOCK,
  input  wire logic        I_ARST_N,
  // Measured negative sequence magnitude in percent of nominal, and its strobe.
  input  wire logic [7:0]  I_NEG_SEQ_PCT,
  input  wire logic        I_NEG_SEQ_VALID,
  // Blocking input from user logic, asynchronous to this block.
  input  wire logic        I_BLOCK_INPUT,
  // AXI4-Lite write address channel.
  input  wire logic [11:0] I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  // AXI4-Lite write data channel.
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  // AXI4-Lite write response channel.
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  // AXI4-Lite read address channel.
  input  wire logic [11:0] I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  // AXI4-Lite read data channel.
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  // Protection outputs and interrupt.
  output logic             O_GENERAL_START_OUT,
  output logic             O_GENERAL_TRIP_OUT,
  output logic             O_IRQ
);

  // Block input is from another domain, so it is synchronised first.
  logic blk_meta_q, blk_sync_q;
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      blk_meta_q <= 1'b0;
      blk_sync_q <= 1'b0;
    end else begin
      blk_meta_q <= I_BLOCK_INPUT;
      blk_sync_q <= blk_meta_q;
    end
  end

  // Configuration and interrupt registers.
  nsov_pkg::nsov_cfg_s cfg_q, cfg_d;
  logic [7:0]  level_q, level_d;
  logic [15:0] delay_q, delay_d;
  logic [2:0]  irq_stat_q, irq_stat_d;
  logic [2:0]  irq_mask_q, irq_mask_d;
  logic [7:0]  meas_q, meas_d;

  // Write channel state: address and data are latched independently.
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic [1:0]  bresp_q, bresp_d;
  // Read channel state.
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;

  // Protection state.
  nsov_pkg::nsov_state_e state_q, state_d;
  logic [$clog2(CYC_PER_MS)-1:0] tick_q, tick_d;
  logic [15:0] ms_q, ms_d;
  logic        gen_st_q, gen_st_d, gen_tr_q, gen_tr_d, irq_q, irq_d;
  nsov_pkg::nsov_evt_s evt;
  logic        above, blocked, wr_fire;

  // Comparison uses only the negative sequence magnitude; strict greater-than. [RQ5] [RQ1]
  assign above   = meas_q > level_q;                    // [RQ1] [RQ12]
  assign blocked = !cfg_q.enable || blk_sync_q;         // [RQ3] [RQ11]
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

  // Characteristic stage: definite timer counts whole milliseconds while above level.
  always_comb begin
    state_d = state_q;
    tick_d  = tick_q;
    ms_d    = ms_q;
    meas_d  = I_NEG_SEQ_VALID ? I_NEG_SEQ_PCT : meas_q; // [RQ7]
    if (blocked || !above) begin
      // Falling back or blocking clears the timer at once. [RQ12]
      state_d = nsov_pkg::NSOV_IDLE;
      tick_d  = '0;
      ms_d    = '0;
    end else begin
      case (state_q)
        nsov_pkg::NSOV_IDLE: begin
          state_d = nsov_pkg::NSOV_TIMING;
          tick_d  = '0;
          ms_d    = '0;
        end
        nsov_pkg::NSOV_TIMING: begin
          // Fixed time, independent of the excess over the level. [RQ4]
          if (tick_q == $bits(tick_q)'(CYC_PER_MS - 1)) begin
            tick_d = '0;
            ms_d   = ms_q + 16'd1;
            if (ms_q + 16'd1 >= delay_q) begin
              state_d = nsov_pkg::NSOV_TRIPPED;         // [RQ2]
            end
          end else begin
            tick_d = tick_q + $bits(tick_q)'(1);
          end
        end
        default: begin
          state_d = nsov_pkg::NSOV_TRIPPED;
        end
      endcase
    end
  end

  // Decision stage: combines internal states with flags and blocking. [RQ6]
  always_comb begin
    gen_st_d = !blocked && above && state_q != nsov_pkg::NSOV_IDLE;     // [RQ1] [RQ3]
    gen_tr_d = !blocked && above && state_q == nsov_pkg::NSOV_TRIPPED
               && !cfg_q.start_only;                                    // [RQ2] [RQ10]
    evt.start = gen_st_d && !gen_st_q;
    evt.trip  = gen_tr_d && !gen_tr_q;
    evt.drop  = !gen_st_d && gen_st_q;
  end

  // Bus write decode, register updates and sticky interrupt bits.
  // Settings outside the documented range are clamped so the timer never misbehaves.
  always_comb begin
    cfg_d      = cfg_q;
    level_d    = level_q;
    delay_d    = delay_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    aw_have_d  = aw_have_q;
    w_have_d   = w_have_q;
    awaddr_d   = awaddr_q;
    wdata_d    = wdata_q;
    wstrb_d    = wstrb_q;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    if (I_AWVALID && !aw_have_q) begin
      aw_have_d = 1'b1;
      awaddr_d  = I_AWADDR;
    end
    if (I_WVALID && !w_have_q) begin
      w_have_d = 1'b1;
      wdata_d  = I_WDATA;
      wstrb_d  = I_WSTRB;
    end
    if (bvalid_q && I_BREADY) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = `NSOV_RESP_OKAY;
      if (awaddr_q[11:2] == `NSOV_OFF_CTRL >> 2) begin
        if (wstrb_q[0]) begin
          cfg_d.enable     = wdata_q[`NSOV_CTRL_ENABLE];
          cfg_d.start_only = wdata_q[`NSOV_CTRL_START_ONLY];      // [RQ10]
        end
      end else if (awaddr_q[11:2] == `NSOV_OFF_LEVEL >> 2) begin
        if (wstrb_q[0]) begin
          level_d = wdata_q[7:0] < `NSOV_LEVEL_MIN ? `NSOV_LEVEL_MIN :
                    wdata_q[7:0] > `NSOV_LEVEL_MAX ? `NSOV_LEVEL_MAX : wdata_q[7:0]; // [RQ8]
        end
      end else if (awaddr_q[11:2] == `NSOV_OFF_DELAY >> 2) begin
        if (wstrb_q[1:0] == 2'b11) begin
          delay_d = wdata_q[15:0] < `NSOV_DELAY_MIN ? `NSOV_DELAY_MIN :
                    wdata_q[15:0] > `NSOV_DELAY_MAX ? `NSOV_DELAY_MAX : wdata_q[15:0]; // [RQ9]
        end
      end else if (awaddr_q[11:2] == `NSOV_OFF_IRQ_STAT >> 2) begin
        if (wstrb_q[0]) begin
          irq_stat_d = irq_stat_q & ~wdata_q[2:0];
        end
      end else if (awaddr_q[11:2] == `NSOV_OFF_IRQ_MASK >> 2) begin
        if (wstrb_q[0]) begin
          irq_mask_d = wdata_q[2:0];
        end
      end else if (awaddr_q[11:2] == `NSOV_OFF_STATUS >> 2 ||
                   awaddr_q[11:2] == `NSOV_OFF_ELAPSED >> 2) begin
        bresp_d = `NSOV_RESP_OKAY;
      end else begin
        bresp_d = `NSOV_RESP_SLVERR;
      end
    end
    // Hardware set wins over a software clear in the same cycle.
    irq_stat_d = irq_stat_d | {evt.drop, evt.trip, evt.start};
    irq_d      = |(irq_stat_d & irq_mask_d);
  end

  // Bus read decode; one read at a time, answered the cycle after the address.
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && I_RREADY) begin
      rvalid_d = 1'b0;
    end
    if (I_ARVALID && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d  = `NSOV_RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      if (I_ARADDR[11:2] == `NSOV_OFF_CTRL >> 2) begin
        rdata_d[1:0] = {cfg_q.start_only, cfg_q.enable};
      end else if (I_ARADDR[11:2] == `NSOV_OFF_LEVEL >> 2) begin
        rdata_d[7:0] = level_q;
      end else if (I_ARADDR[11:2] == `NSOV_OFF_DELAY >> 2) begin
        rdata_d[15:0] = delay_q;
      end else if (I_ARADDR[11:2] == `NSOV_OFF_STATUS >> 2) begin
        rdata_d[15:0] = {meas_q, 3'b000, blk_sync_q, state_q, gen_tr_q, gen_st_q};
      end else if (I_ARADDR[11:2] == `NSOV_OFF_IRQ_STAT >> 2) begin
        rdata_d[2:0] = irq_stat_q;
      end else if (I_ARADDR[11:2] == `NSOV_OFF_IRQ_MASK >> 2) begin
        rdata_d[2:0] = irq_mask_q;
      end else if (I_ARADDR[11:2] == `NSOV_OFF_ELAPSED >> 2) begin
        rdata_d[15:0] = ms_q;
      end else begin
        rresp_d = `NSOV_RESP_SLVERR;
      end
    end
  end

  // Registers only; all next values come from the processes above.
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cfg_q      <= '{enable: 1'b1, start_only: 1'b0};
      level_q    <= `NSOV_LEVEL_RST;
      delay_q    <= `NSOV_DELAY_RST;
      irq_stat_q <= 3'h0;
      irq_mask_q <= 3'h0;
      meas_q     <= 8'h00;
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      awaddr_q   <= 12'h000;
      wdata_q    <= 32'h0000_0000;
      wstrb_q    <= 4'h0;
      bvalid_q   <= 1'b0;
      bresp_q    <= 2'b00;
      rvalid_q   <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= 2'b00;
      state_q    <= nsov_pkg::NSOV_IDLE;
      tick_q     <= '0;
      ms_q       <= 16'h0000;
      gen_st_q   <= 1'b0;
      gen_tr_q   <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      cfg_q      <= cfg_d;
      level_q    <= level_d;
      delay_q    <= delay_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      meas_q     <= meas_d;
      aw_have_q  <= aw_have_d;
      w_have_q   <= w_have_d;
      awaddr_q   <= awaddr_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
      state_q    <= state_d;
      tick_q     <= tick_d;
      ms_q       <= ms_d;
      gen_st_q   <= gen_st_d;
      gen_tr_q   <= gen_tr_d;
      irq_q      <= irq_d;
    end
  end

  // Outputs straight from flip-flops.
  assign O_AWREADY           = !aw_have_q;
  assign O_WREADY            = !w_have_q;
  assign O_BVALID            = bvalid_q;
  assign O_BRESP             = bresp_q;
  assign O_ARREADY           = !rvalid_q;
  assign O_RVALID            = rvalid_q;
  assign O_RDATA             = rdata_q;
  assign O_RRESP             = rresp_q;
  assign O_GENERAL_START_OUT = gen_st_q;
  assign O_GENERAL_TRIP_OUT  = gen_tr_q;
  assign O_IRQ               = irq_q;

endmodule // nsov_trip

//--- shared/nsov_defines.svh
// Register offsets, field positions, reset values and timing counts of the overvoltage block.
`ifndef NSOV_DEFINES_SVH
`define NSOV_DEFINES_SVH
`define NSOV_OFF_CTRL       12'h000
`define NSOV_OFF_LEVEL      12'h004
`define NSOV_OFF_DELAY      12'h008
`define NSOV_OFF_STATUS     12'h00C
`define NSOV_OFF_IRQ_STAT   12'h010
`define NSOV_OFF_IRQ_MASK   12'h014
`define NSOV_OFF_ELAPSED    12'h018
`define NSOV_CTRL_ENABLE    0
`define NSOV_CTRL_START_ONLY 1
`define NSOV_LEVEL_MIN      8'd2
`define NSOV_LEVEL_MAX      8'd40
`define NSOV_LEVEL_RST      8'd30
`define NSOV_DELAY_MIN      16'd50
`define NSOV_DELAY_MAX      16'd60000
`define NSOV_DELAY_RST      16'd100
`define NSOV_CLK_HZ         10000000
`define NSOV_MS_PER_S       1000
`define NSOV_CYC_PER_MS     (`NSOV_CLK_HZ / `NSOV_MS_PER_S)
`define NSOV_IRQ_START      0
`define NSOV_IRQ_TRIP       1
`define NSOV_IRQ_DROP       2
`define NSOV_RESP_OKAY      2'b00
`define NSOV_RESP_SLVERR    2'b10
`endif

//--- shared/nsov_pkg.sv
// Types shared by the overvoltage block.
package nsov_pkg;
  typedef enum logic [1:0] {
    NSOV_IDLE    = 2'b00,
    NSOV_TIMING  = 2'b01,
    NSOV_TRIPPED = 2'b11
  } nsov_state_e;
  typedef struct packed {
    logic enable;
    logic start_only;
  } nsov_cfg_s;
  typedef struct packed {
    logic drop;
    logic trip;
    logic start;
  } nsov_evt_s;
endpackage

//--- dv/nsov_trip_asserts.sv
// Port-level checks of the overvoltage block.
`timescale 1ns/1ns
module nsov_trip_asserts #(
  parameter int unsigned CYC_PER_MS = 10
) (
  // Clock, reset and blocking input.
  input wire logic        I_CLOCK,
  input wire logic        I_ARST_N,
  input wire logic        I_BLOCK_INPUT,
  // Register bus handshakes.
  input wire logic        I_AWVALID,
  input wire logic        O_AWREADY,
  input wire logic        I_WVALID,
  input wire logic        O_WREADY,
  input wire logic        O_BVALID,
  input wire logic        I_ARVALID,
  input wire logic        O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic        O_RVALID,
  input wire logic        I_RREADY,
  // Protection outputs.
  input wire logic        O_GENERAL_START_OUT,
  input wire logic        O_GENERAL_TRIP_OUT
);
  logic [15:0] run_q;
  logic [15:0] run_d;
  default clocking dc @(posedge I_CLOCK); endclocking
  default disable iff (!I_ARST_N);
  // Length of the present start, saturating so a long start never wraps to a short one.
  always_comb begin
    run_d = O_GENERAL_START_OUT ? run_q + {15'h0, ~&run_q} : 16'h0;
  end
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      run_q <= 16'h0;
    end else begin
      run_q <= run_d;
    end
  end
  // The shortest settable delay bounds how early a trip may come; margin covers pipeline.
  AST_TRIP_NEEDS_START: assert property (O_GENERAL_TRIP_OUT |-> O_GENERAL_START_OUT)
    else $error("trip seen without start");
  AST_TRIP_DELAY: assert property ($rose(O_GENERAL_TRIP_OUT) |->
    int'(run_q) >= 50 * CYC_PER_MS - 4) else $error("trip came before the delay");
  AST_BLOCK_DROP: assert property (I_BLOCK_INPUT [*4] |=>
    !O_GENERAL_START_OUT && !O_GENERAL_TRIP_OUT) else $error("outputs stay while blocked");
  AST_READ_LAT: assert property (I_ARVALID && O_ARREADY |=> O_RVALID) // [AXI]
    else $error("read answer late");
  AST_RVALID_HOLD: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA)) // [AXI]
    else $error("read data not held");
  AST_READ_DONE: assert property (O_RVALID && I_RREADY |=> !O_RVALID) // [AXI]
    else $error("read answer kept after handshake");
  AST_WRITE_RESP: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> // [AXI]
    ##[1:3] O_BVALID) else $error("write answer late");
  // New items may be taken while an answer waits, so check the pairing instead.
  AST_WRITE_PAIRED: assert property (!O_AWREADY && !O_WREADY && !O_BVALID |=> O_BVALID) // [AXI]
    else $error("paired write not answered");
endmodule // nsov_trip_asserts

//--- dv/nsov_src.sv
// Behavioural source of the measured negative sequence magnitude.
`timescale 1ns/1ns
module nsov_src (
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  // Magnitude the bench wants shown.
  input  wire logic [7:0] i_target,
  // Magnitude and strobe towards the block.
  output logic [7:0]      o_pct,
  output logic            o_valid
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  // A new value every fourth tick, like a slow calculation loop.
  always_comb begin
    cnt_d = cnt_q + 2'h1;
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  // Off the strobe the inverse is shown, so a capture without strobe is caught.
  assign o_valid = (cnt_q == 2'h3);
  assign o_pct   = o_valid ? i_target : ~i_target;
endmodule // nsov_src

//--- dv/tb.sv
// Self-checking bench of the overvoltage block.
`timescale 1ns/1ns
`include "nsov_defines.svh"
module tb;
  logic        clk, arst_n, blk, awvalid, wvalid, bready, arvalid, rready, pvalid;
  logic        awready, wready, bvalid, arready, rvalid, start, trip, irq;
  logic [1:0]  bresp, rresp;
  logic [7:0]  tgt, pct;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [33:0] exp_q[$];
  logic [31:0] exp_m[$];
  logic [1:0]  exp_b[$];
  int          num_errors, tests_run, cyc;
  nsov_trip #(.CYC_PER_MS(10)) nsov_trip_inst (.I_CLOCK(clk), .I_ARST_N(arst_n),
    .I_NEG_SEQ_PCT(pct), .I_NEG_SEQ_VALID(pvalid), .I_BLOCK_INPUT(blk),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
    .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
    .I_RREADY(rready), .O_GENERAL_START_OUT(start), .O_GENERAL_TRIP_OUT(trip), .O_IRQ(irq));
  nsov_src nsov_src_inst (.i_clk(clk), .i_arst_n(arst_n), .i_target(tgt), .o_pct(pct),
    .o_valid(pvalid));
  // Clock of 100 ns and a cycle limit that cuts a hang short.
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      end_sim();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Write: both channels offered together, each dropped once taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok = 1'h0;
    logic w_ok = 1'h0;
    // Offsets past the last register are unmapped and must be refused.
    exp_b.push_back(a > `NSOV_OFF_ELAPSED ? `NSOV_RESP_SLVERR : `NSOV_RESP_OKAY);
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        awvalid <= 1'h0;
        aw_ok = 1'h1;
      end
      if (wvalid && wready) begin
        wvalid <= 1'h0;
        w_ok = 1'h1;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'h0;
  endtask
  // Read; ready is raised late on purpose so the slave must hold its answer.
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [33:0] e);
    exp_m.push_back(m);
    exp_q.push_back(e);
    @(posedge clk);
    {araddr, arvalid} <= {a, 1'h1};
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    @(posedge clk);
    rready <= 1'h1;
    do @(posedge clk); while (!rvalid);
    rready <= 1'h0;
  endtask
  // Each finished read or write answer is compared with the oldest note.
  always @(posedge clk) begin
    if (rvalid && rready) begin
      check({rresp, rdata & exp_m.pop_front()}, exp_q.pop_front()); // [AXI]
    end
    if (bvalid && bready) begin
      check(34'(bresp), 34'(exp_b.pop_front())); // [AXI]
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    {blk, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {arst_n, tgt, seed, num_errors, tests_run, cyc} = {1'h0, 8'h0, 32'hB7BE, 96'h0};
    wt(2);
    arst_n <= 1'h1;
    rd(`NSOV_OFF_CTRL, 32'hFF, 34'h1);
    rd(`NSOV_OFF_LEVEL, 32'hFF, 34'h1E);
    rd(`NSOV_OFF_DELAY, 32'hFFFF, 34'h64);
    rd(12'h100, 32'h0, 34'h200000000); // [AXI]
    wr(12'h100, 32'h0); // [AXI]
    $display("test reset values done");
    tgt <= 8'h1E;
    wt(20);
    rd(`NSOV_OFF_STATUS, 32'h3, 34'h0);
    tgt <= 8'h1F;
    wt(20);
    rd(`NSOV_OFF_STATUS, 32'h3, 34'h1);
    $display("test level boundary done");
    wr(`NSOV_OFF_DELAY, 32'h32);
    wr(`NSOV_OFF_IRQ_MASK, 32'h7);
    tgt <= 8'h0;
    wt(20);
    wr(`NSOV_OFF_IRQ_STAT, 32'h7);
    rd(`NSOV_OFF_IRQ_STAT, 32'h7, 34'h0); // [IRQ]
    tgt <= 8'(32'h1F + rnd() % 32'd200);
    wt(400);
    rd(`NSOV_OFF_STATUS, 32'h3, 34'h1);
    wt(150);
    rd(`NSOV_OFF_STATUS, 32'h3, 34'h3);
    check(34'({trip, start}), 34'h3);
    rd(`NSOV_OFF_ELAPSED, 32'hFFFF, 34'h32);
    rd(`NSOV_OFF_IRQ_STAT, 32'h7, 34'h3); // [IRQ]
    check(34'(irq), 34'h1); // [IRQ]
    wr(`NSOV_OFF_IRQ_MASK, 32'h0);
    wt(2);
    check(34'(irq), 34'h0); // [IRQ]
    wr(`NSOV_OFF_IRQ_STAT, 32'h3);
    rd(`NSOV_OFF_IRQ_STAT, 32'h3, 34'h0); // [IRQ]
    $display("test delayed trip done");
    wr(`NSOV_OFF_CTRL, 32'h3);
    wt(600);
    rd(`NSOV_OFF_STATUS, 32'h3, 34'h1);
    wr(`NSOV_OFF_CTRL, 32'h1);
    blk <= 1'h1;
    wt(10);
    rd(`NSOV_OFF_STATUS, 32'h3, 34'h0);
    check(34'({trip, start}), 34'h0);
    rd(`NSOV_OFF_IRQ_STAT, 32'h4, 34'h4); // [IRQ]
    blk <= 1'h0;
    wr(`NSOV_OFF_CTRL, 32'h0);
    wt(10);
    rd(`NSOV_OFF_STATUS, 32'h3, 34'h0);
    $display("test suppression done");
    wr(`NSOV_OFF_LEVEL, 32'h50);
    rd(`NSOV_OFF_LEVEL, 32'hFF, 34'h28);
    wr(`NSOV_OFF_DELAY, 32'hFFFF);
    rd(`NSOV_OFF_DELAY, 32'hFFFF, 34'hEA60);
    $display("test setting limits done");
    end_sim();
  end
endmodule // tb
bind nsov_trip nsov_trip_asserts #(.CYC_PER_MS(CYC_PER_MS)) nsov_trip_asserts_inst (
  .I_CLOCK, .I_ARST_N, .I_BLOCK_INPUT, .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY,
  .O_BVALID, .I_ARVALID, .O_ARREADY, .O_RDATA, .O_RVALID, .I_RREADY,
  .O_GENERAL_START_OUT, .O_GENERAL_TRIP_OUT);
